/* src/stc_core.sv */
// Notes on behaviour
// [RQ1] half-duplex bit selects single-line mode
// [RQ2] half-duplex: rx pin ignored, open-drain loopback
// [RQ3] software clears other modes before half-duplex
// [RQ4] half-duplex: enable receive after complete
// [RQ5] frame: start, 7/8/9 data, parity, stop
// [RQ6] parity select: 0 even, 1 odd
// [RQ7] parity bit fixes count of ones
// [RQ8] stop length 1, 0.5, 2, 1.5
// [RQ9] lsb first, low start, high stops
// [RQ10] enabled transmitter idles line high
// [RQ11] write during frame waits in buffer
// [RQ12] write while idle loads shifter at once
// [RQ13] data write clears empty flag; irq
// [RQ14] frame done, buffer empty: complete flag
// [RQ15] enabling transmitter sends one idle frame
// [RQ16] break frame after character, self clears
// [RQ17] software keeps transmitter on mid frame
// [RQ18] software follows transmit setup sequence
// [RQ19] software waits complete before disabling
// [RQ20] receive lsb first; full flag, irq
// [RQ21] full flag cleared by read or zero; the zero write is ignored while dma is set
// [RQ22] overrun, noise, framing errors flagged
// [RQ23] software keeps receiver on mid char
// [RQ24] baud divider ticks; centre sampling
//
// Design decisions made here: the APB slave port and the register addresses.
`default_nettype none
`include "stc_consts.svh"
module stc_core (
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire stc_pkg::stc_apb_req_type i_apb,
  output var  stc_pkg::stc_apb_rsp_type o_apb,
  input  wire logic                     i_rx,
  input  wire logic                     i_tx_pin,
  output logic                          o_tx_pin,
  output logic                          o_tx_pin_oe_n,
  output logic                          o_irq,
  output logic                          o_dma_rx_req
);
  import stc_pkg::*;

  // parity that completes d; error term on a received word
  function automatic logic parity_bit(input logic [8:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // start bit in bit 0, then data lsb first, parity in the top data slot
  function automatic logic [9:0] build_frame(input logic [8:0] d, input logic len9,
                                             input logic pen, input logic odd);
    logic [8:0] b;
    b = d;
    if (pen && len9) begin
      b[8] = parity_bit({1'b0, d[7:0]}, odd);
    end else if (pen) begin
      b[7] = parity_bit({2'b00, d[6:0]}, odd);
    end
    if (!len9) begin
      b[8] = 1'b1; // never shifted out in 8-bit frames
    end
    return {b, 1'b0};
  endfunction

  // stop length in oversample ticks
  function automatic logic [5:0] stop_ticks(input stc_stop_type s);
    unique case (s)
      STOP_ONE:      return `STC_STOP_ONE;
      STOP_HALF:     return `STC_STOP_HALF;
      STOP_TWO:      return `STC_STOP_TWO;
      STOP_ONE_HALF: return `STC_STOP_1P5;
    endcase
  endfunction

  logic [9:0]       ctrl1;      // control_reg_one
  logic [3:0]       ctrl2;      // control_reg_two
  logic [3:0]       ctrl3;      // control_reg_three
  logic [15:0]      baud;       // baud_reg, 12.4 divider
  logic [8:0]       tx_buf;     // transmit buffer
  logic [8:0]       rx_data;    // receive buffer
  logic             txe;        // tx_buffer_empty_flag
  logic             txc;        // tx_complete_flag
  logic             rxf;        // rx_buffer_full_flag
  logic             fe;         // framing error
  logic             ne;         // noise error
  logic             ore;        // overrun error
  logic             pe;         // parity error
  logic             sts_seen;   // status read, arms clear
  logic [11:0]      div_cnt;    // baud divider count
  logic             tick;       // 16x oversample enable
  logic             rx_m;       // rx pin sync stages
  logic             rx_s;
  logic             tp_m;       // tx wire readback sync
  logic             tp_s;
  logic             rx_prev;    // line a cycle back
  stc_tx_state_type tx_state;
  logic [9:0]       tx_sh;      // transmit shift register
  logic [3:0]       tx_bits;    // bit index in frame
  logic [3:0]       tx_ph;      // tick phase inside a bit
  logic [5:0]       tx_stop;    // stop tick count
  logic             tx_brk;     // current frame is a break
  logic             tx_line;    // logical transmit level
  stc_rx_state_type rx_state;
  logic [8:0]       rx_sh;      // receive shift register
  logic [3:0]       rx_bits;
  logic [3:0]       rx_ph;
  logic [1:0]       rx_win;     // earlier window samples
  logic             rx_nz;      // noise seen in this character
  logic             rx_done;    // character complete, one cycle
  logic             rx_bad;     // stop bit read low

  // configuration decode
  logic unit_en, tx_on, rx_on, len9, pen, odd, half, dma;
  assign unit_en = ctrl1[`STC_B_UNIT_EN];
  assign tx_on   = unit_en & ctrl1[`STC_B_TX_EN];
  assign rx_on   = unit_en & ctrl1[`STC_B_RX_EN];
  assign len9    = ctrl1[`STC_B_LEN9];
  assign pen     = ctrl1[`STC_B_PAR_EN];
  assign odd     = ctrl1[`STC_B_PAR_SEL]; // [RQ6]
  assign half    = ctrl3[`STC_B_HALF];    // [RQ1]
  assign dma     = ctrl3[`STC_B_DMA_RX];

  // a transfer takes effect on the edge that sees pready
  logic acc, wr, rd, hit;
  assign acc = i_apb.psel & i_apb.penable & o_apb.pready;
  assign wr  = acc & i_apb.pwrite;
  assign rd  = acc & ~i_apb.pwrite;
  assign hit = (i_apb.paddr[1:0] == 2'b00) && (i_apb.paddr <= `STC_OFF_CTRL3);
  logic wr_data, rd_data, wr_sts, rd_sts;
  assign wr_data = wr & (i_apb.paddr == `STC_OFF_DATA);
  assign rd_data = rd & (i_apb.paddr == `STC_OFF_DATA);
  assign wr_sts  = wr & (i_apb.paddr == `STC_OFF_STATUS);
  assign rd_sts  = rd & (i_apb.paddr == `STC_OFF_STATUS);

  // engine events
  logic tx_load, tx_done, brk_req, rx_line;
  logic [8:0] rx_word;
  logic [2:0] rx_w3;
  assign brk_req = ctrl1[`STC_B_BREAK];
  // same-cycle data write waits a cycle; stop end loads at once, no idle gap
  assign tx_load = tx_on & ~brk_req & ~txe & ~wr_data & ((tx_state == TX_READY) | tx_done);
  assign tx_done = tx_on & (tx_state == TX_STOP) & tick
                 & (tx_stop == stop_ticks(stc_stop_type'(ctrl2[1:0])) - 6'h01);
  assign rx_line = half ? tp_s : rx_s; // [RQ2]
  assign rx_word = len9 ? rx_sh : {1'b0, rx_sh[8:1]};
  assign rx_w3   = {rx_win, rx_line};

  // one wait state per transfer; unmapped answers slverr
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_apb.paddr)
      `STC_OFF_STATUS: begin
        rd_mux[`STC_B_FE]  = fe;
        rd_mux[`STC_B_NE]  = ne;
        rd_mux[`STC_B_ORE] = ore;
        rd_mux[`STC_B_PE]  = pe;
        rd_mux[`STC_B_RXF] = rxf;
        rd_mux[`STC_B_TXC] = txc;
        rd_mux[`STC_B_TXE] = txe;
      end
      `STC_OFF_DATA:  rd_mux[8:0]  = rx_data;
      `STC_OFF_BAUD:  rd_mux[15:0] = baud;
      `STC_OFF_CTRL1: rd_mux[9:0]  = ctrl1;
      `STC_OFF_CTRL2: rd_mux[3:0]  = ctrl2;
      `STC_OFF_CTRL3: rd_mux[3:0]  = ctrl3;
      default:        rd_mux       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_apb <= '0;
    end else begin
      o_apb.pready  <= i_apb.psel & i_apb.penable & ~o_apb.pready;
      o_apb.pslverr <= i_apb.psel & i_apb.penable & ~o_apb.pready & ~hit;
      o_apb.prdata  <= (i_apb.psel & i_apb.penable & ~o_apb.pready & ~i_apb.pwrite)
                       ? rd_mux : 32'h0000_0000;
    end
  end

  // control registers; software write beats break self clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl1 <= `STC_RST_CTRL1;
      ctrl2 <= `STC_RST_CTRL;
      ctrl3 <= `STC_RST_CTRL;
      baud  <= `STC_RST_BAUD;
    end else begin
      if (wr && i_apb.paddr == `STC_OFF_CTRL1) begin
        ctrl1 <= i_apb.pwdata[9:0];
      end else if (tx_done && tx_brk) begin
        ctrl1[`STC_B_BREAK] <= 1'b0; // [RQ16]
      end
      if (wr && i_apb.paddr == `STC_OFF_CTRL2) begin
        ctrl2 <= i_apb.pwdata[3:0]; // [RQ8]
      end
      if (wr && i_apb.paddr == `STC_OFF_CTRL3) begin
        ctrl3 <= i_apb.pwdata[3:0]; // [RQ1]
      end
      if (wr && i_apb.paddr == `STC_OFF_BAUD) begin
        baud <= i_apb.pwdata[15:0];
      end
      if (wr_data) begin
        tx_buf <= i_apb.pwdata[8:0]; // [RQ11]
      end
    end
  end

  // oversample divider: fraction dropped, zero acts as one
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !unit_en) begin
      div_cnt <= 12'h000;
      tick    <= 1'b0;
    end else if (div_cnt == 12'h000) begin
      div_cnt <= (baud[15:4] == 12'h000) ? 12'h000 : baud[15:4] - 12'h001; // [RQ24]
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 12'h001;
      tick    <= 1'b0;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rx_m    <= 1'b1;
      rx_s    <= 1'b1;
      tp_m    <= 1'b1;
      tp_s    <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_m    <= i_rx;
      rx_s    <= rx_m;
      tp_m    <= i_tx_pin;
      tp_s    <= tp_m;
      rx_prev <= rx_line;
    end
  end

  // transmitter; dropping the enable mid frame cuts the frame short
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !tx_on) begin
      tx_state <= TX_OFF;
      tx_sh    <= 10'h3ff;
      tx_bits  <= 4'h0;
      tx_ph    <= 4'h0;
      tx_stop  <= 6'h00;
      tx_brk   <= 1'b0;
      tx_line  <= 1'b1;
    end else begin
      unique case (tx_state)
        TX_OFF: begin
          tx_sh    <= 10'h3ff; // [RQ15]
          tx_brk   <= 1'b0;
          tx_bits  <= 4'h0;
          tx_ph    <= 4'h0;
          tx_state <= TX_BITS;
        end
        TX_READY: begin
          tx_line <= 1'b1; // [RQ10]
          tx_bits <= 4'h0;
          tx_ph   <= 4'h0;
          if (brk_req) begin
            tx_sh    <= 10'h000; // [RQ16]
            tx_brk   <= 1'b1;
            tx_state <= TX_BITS;
          end
        end
        TX_BITS: begin
          tx_line <= tx_sh[0]; // [RQ9]
          if (tick) begin
            tx_ph <= tx_ph + 4'h1;
            if (tx_ph == `STC_PH_LAST) begin
              tx_sh <= {1'b1, tx_sh[9:1]};
              if (tx_bits == (len9 ? `STC_TX_LAST9 : `STC_TX_LAST8)) begin
                tx_stop  <= 6'h00;
                tx_state <= TX_STOP;
              end else begin
                tx_bits <= tx_bits + 4'h1;
              end
            end
          end
        end
        TX_STOP: begin
          tx_line <= 1'b1; // [RQ9]
          if (tx_done) begin
            tx_state <= TX_READY; // [RQ11]
          end else if (tick) begin
            tx_stop <= tx_stop + 6'h01;
          end
        end
      endcase
      // load from idle or straight at the end of a stop
      if (tx_load) begin
        tx_sh    <= build_frame(tx_buf, len9, pen, odd); // [RQ5] [RQ7] [RQ12]
        tx_brk   <= 1'b0;
        tx_bits  <= 4'h0;
        tx_ph    <= 4'h0;
        tx_state <= TX_BITS;
      end
    end
  end

  // half-duplex only pulls low; normal mode drives both levels
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_tx_pin      <= 1'b1;
      o_tx_pin_oe_n <= 1'b1;
    end else if (half) begin
      o_tx_pin      <= 1'b0;
      o_tx_pin_oe_n <= tx_line; // [RQ2]
    end else begin
      o_tx_pin      <= tx_line;
      o_tx_pin_oe_n <= 1'b0;
    end
  end

  // receiver: start checked at mid bit, bits by 3-sample majority
  always_ff @(posedge i_clk) begin
    if (!i_rstn || !rx_on) begin
      rx_state <= RX_IDLE;
      rx_ph    <= 4'h0;
      rx_bits  <= 4'h0;
      rx_win   <= 2'b11;
      rx_nz    <= 1'b0;
      rx_done  <= 1'b0;
      rx_bad   <= 1'b0;
      rx_sh    <= 9'h000;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          rx_ph <= 4'h0;
          if (rx_prev && !rx_line) begin
            rx_state <= RX_START; // [RQ24]
          end
        end
        RX_START: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == `STC_PH_START) begin
              rx_ph    <= 4'h0;
              rx_bits  <= 4'h0;
              rx_nz    <= 1'b0;
              rx_state <= rx_line ? RX_IDLE : RX_BITS; // glitch is not a start
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph >= `STC_PH_WIN && rx_ph != `STC_PH_LAST) begin
              rx_win <= {rx_win[0], rx_line};
            end
            if (rx_ph == `STC_PH_LAST) begin
              rx_sh <= {(rx_w3[2] & rx_w3[1]) | (rx_w3[2] & rx_w3[0]) | (rx_w3[1] & rx_w3[0]),
                        rx_sh[8:1]}; // [RQ20]
              rx_nz <= rx_nz | ~((&rx_w3) | ~(|rx_w3)); // [RQ22]
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == (len9 ? `STC_RX_LAST9 : `STC_RX_LAST8)) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == `STC_PH_LAST) begin
              rx_bad   <= ~rx_line; // [RQ22]
              rx_done  <= 1'b1;
              rx_state <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // status flags; a hardware set beats a same-cycle clear, except txe, where a data write wins over a load
  logic rxf_clr, err_clr;
  assign rxf_clr = rd_data | (wr_sts & ~dma & ~i_apb.pwdata[`STC_B_RXF]); // [RQ21]
  assign err_clr = rd_data & sts_seen;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      txe      <= 1'b1;
      txc      <= 1'b1;
      rxf      <= 1'b0;
      fe       <= 1'b0;
      ne       <= 1'b0;
      ore      <= 1'b0;
      pe       <= 1'b0;
      sts_seen <= 1'b0;
      rx_data  <= 9'h000;
    end else begin
      if (wr_data) begin
        txe <= 1'b0; // [RQ13]
      end else if (tx_load) begin
        txe <= 1'b1; // [RQ12]
      end
      if (tx_done && txe) begin
        txc <= 1'b1; // [RQ14]
      end else if (wr_data || (wr_sts && !i_apb.pwdata[`STC_B_TXC])) begin
        txc <= 1'b0;
      end
      sts_seen <= rd_sts | (sts_seen & ~rd_data);
      if (rx_done && rxf && !rxf_clr) begin
        ore <= 1'b1; // [RQ22]
      end else if (rx_done) begin
        rx_data <= rx_word; // [RQ20]
        rxf     <= 1'b1;    // [RQ20]
        fe      <= rx_bad | (fe & ~err_clr);
        ne      <= rx_nz | (ne & ~err_clr);
        pe      <= (pen & parity_bit(rx_word, odd)) | (pe & ~err_clr);
      end else if (rxf_clr) begin
        rxf <= 1'b0; // [RQ21]
      end
      if (err_clr && !rx_done) begin
        fe  <= 1'b0;
        ne  <= 1'b0;
        ore <= 1'b0;
        pe  <= 1'b0;
      end
    end
  end

  // interrupt and dma request levels
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_irq        <= 1'b0;
      o_dma_rx_req <= 1'b0;
    end else begin
      o_irq <= (txe & ctrl1[`STC_B_TXE_IE]) | (txc & ctrl1[`STC_B_TXC_IE]) // [RQ13] [RQ14]
             | ((rxf | ore) & ctrl1[`STC_B_RXF_IE]);                      // [RQ20]
      o_dma_rx_req <= rxf & dma; // [RQ21]
    end
  end
endmodule
`default_nettype wire

/* src/stc_consts.svh */
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH
// register byte offsets
`define STC_OFF_STATUS 8'h00
`define STC_OFF_DATA   8'h04
`define STC_OFF_BAUD   8'h08
`define STC_OFF_CTRL1  8'h0c
`define STC_OFF_CTRL2  8'h10
`define STC_OFF_CTRL3  8'h14
// control_reg_one fields
`define STC_B_UNIT_EN  0
`define STC_B_RX_EN    1
`define STC_B_TX_EN    2
`define STC_B_BREAK    3
`define STC_B_RXF_IE   4
`define STC_B_TXC_IE   5
`define STC_B_TXE_IE   6
`define STC_B_PAR_SEL  7
`define STC_B_PAR_EN   8
`define STC_B_LEN9     9
// control_reg_two fields
`define STC_B_STOP_LO  0
`define STC_B_STOP_HI  1
`define STC_B_SYNC_CK  2
`define STC_B_LIN      3
// control_reg_three fields
`define STC_B_HALF     0
`define STC_B_IR       1
`define STC_B_SC       2
`define STC_B_DMA_RX   3
// status_reg fields
`define STC_B_FE       0
`define STC_B_NE       1
`define STC_B_ORE      2
`define STC_B_PE       3
`define STC_B_RXF      4
`define STC_B_TXC      5
`define STC_B_TXE      6
// reset values
`define STC_RST_CTRL1  10'h000
`define STC_RST_CTRL   4'h0
`define STC_RST_BAUD   16'h0000
// timing counts, in 16x oversample ticks
`define STC_PH_LAST    4'hf
`define STC_PH_START   4'h7
`define STC_PH_WIN     4'hd
`define STC_STOP_HALF  6'h08
`define STC_STOP_ONE   6'h10
`define STC_STOP_1P5   6'h18
`define STC_STOP_TWO   6'h20
// last bit index of a frame (start included) and of received bits
`define STC_TX_LAST8   4'h8
`define STC_TX_LAST9   4'h9
`define STC_RX_LAST8   4'h7
`define STC_RX_LAST9   4'h8
`endif

/* src/stc_pkg.sv */
`default_nettype none
package stc_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } stc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } stc_apb_rsp_type;

  typedef enum logic [1:0] {TX_OFF, TX_BITS, TX_STOP, TX_READY} stc_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} stc_rx_state_type;
  typedef enum logic [1:0] {STOP_ONE, STOP_HALF, STOP_TWO, STOP_ONE_HALF} stc_stop_type;
endpackage
`default_nettype wire

/* bench/stc_core_sva.sv */
`default_nettype none
// port-level checks for the transceiver core
module stc_core_sva (
  input wire logic                     i_clk,
  input wire logic                     i_rstn,
  input wire stc_pkg::stc_apb_req_type i_apb,
  input wire stc_pkg::stc_apb_rsp_type o_apb,
  input wire logic                     i_rx,
  input wire logic                     i_tx_pin,
  input wire logic                     o_tx_pin,
  input wire logic                     o_tx_pin_oe_n,
  input wire logic                     o_irq,
  input wire logic                     o_dma_rx_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import stc_pkg::*;
  logic bad_addr;  // outside the six mapped words
  logic data_rd;   // a data read completes at this edge
  assign bad_addr = (i_apb.paddr[1:0] != 2'b00) || (i_apb.paddr > 8'h14);
  assign data_rd  = i_apb.psel && i_apb.penable && o_apb.pready && !i_apb.pwrite
                    && (i_apb.paddr == 8'h04);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // one wait cycle, then the answer
  apb_wait_a: assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
    else $error("no reply after one wait");
  apb_ready_a: assert property (o_apb.pready |-> i_apb.psel && i_apb.penable)
    else $error("ready outside access");
  apb_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready held over one cycle");
  apb_err_a: assert property (o_apb.pready |-> o_apb.pslverr == bad_addr)
    else $error("slave error vs address");
  apb_idle_a: assert property (!o_apb.pready |-> !o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("reply bits without ready");
  // only one of value and enable may leave the low state
  drive_mode_a: assert property ($past(i_rstn) && o_tx_pin_oe_n |-> !o_tx_pin)
    else $error("pin high while released");
  // shortest wire level is half a bit, 8 clocks
  tx_bit_width_a: assert property ($changed(o_tx_pin) |=> $stable(o_tx_pin)[*7])
    else $error("tx level under half a bit");
  dma_clear_a: assert property (o_dma_rx_req && data_rd |-> ##[1:3] !o_dma_rx_req)
    else $error("dma request kept after read");
endmodule
bind stc_core stc_core_sva chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(i_apb), .o_apb(o_apb),
  .i_rx(i_rx), .i_tx_pin(i_tx_pin), .o_tx_pin(o_tx_pin), .o_tx_pin_oe_n(o_tx_pin_oe_n),
  .o_irq(o_irq), .o_dma_rx_req(o_dma_rx_req));
`default_nettype wire

/* bench/stc_remote_model.sv */
`default_nettype none
// far-end serial device, fixed at 16 clocks a bit
module stc_remote_model (
  input  wire logic       i_clk,
  input  wire logic       i_line,   // tx wire seen at the far end
  input  wire logic       i_half,   // answer over the shared wire
  input  wire logic [3:0] i_nbits,  // bits after the start bit
  output logic            o_rx,     // drive of the receive pin
  output logic            o_pull,   // open-drain pull-down on the wire
  output logic [9:0]      o_word,   // {stop level, bits}
  output logic [15:0]     o_period, // clocks since the previous start edge
  output logic            o_got     // one-cycle frame strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  time        t0;  // previous start edge
  logic [8:0] w;   // bits being gathered
  initial begin
    o_rx = 1'b1;
    o_pull = 1'b0;
    o_word = '0;
    o_period = '0;
    o_got = 1'b0;
    t0 = 0;
  end
  // catch frames; in half-duplex no frames are decoded, own or other
  initial begin
    forever begin
      @(posedge i_clk iff (i_line === 1'b0 && !i_half));
      o_period <= 16'((($time - t0) / 10));
      t0 = $time;
      w = '0;
      repeat (8) @(posedge i_clk);
      for (int k = 0; k < 9; k++) begin
        if (k < i_nbits) begin
          repeat (16) @(posedge i_clk);
          w[k] = i_line;
        end
      end
      // early in stop, so half a stop bit is seen
      repeat (12) @(posedge i_clk);
      o_word <= {i_line, w};
      o_got <= 1'b1;
      @(posedge i_clk);
      o_got <= 1'b0;
    end
  end
  // one bit time; rx pin held low in half-duplex
  task automatic put(input logic b);
    @(posedge i_clk);
    o_pull <= i_half & !b;
    o_rx <= i_half ? 1'b0 : b;
    repeat (15) @(posedge i_clk);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic stop_lvl);
    put(1'b0);
    for (int k = 0; k < nb; k++) put(d[k]);
    put(stop_lvl);
    put(1'b1);
  endtask
endmodule
`default_nettype wire

/* bench/stc_core_tb_top.sv */
`default_nettype none
module stc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import stc_pkg::*;
  logic            i_clk = 1'b0;
  logic            i_rstn = 1'b0;
  stc_apb_req_type apb_req = '0;
  stc_apb_rsp_type apb_rsp;
  logic            rx_pin, tx_pin, tx_oe_n, irq, dma_req, pull, wire_lvl, got;
  logic            half = 1'b0;   // far end uses the shared wire
  logic [3:0]      nbits = 4'h8;  // frame size told to the far end
  logic [9:0]      word;
  logic [15:0]     period;
  int              n_errors = 0;
  int              check_count = 0;
  integer          seed = 32'h12c2;
  logic [64:0]     bus_q[$];      // {error, mask, value}
  logic [26:0]     ser_q[$];      // {period used, period, frame bits}
  logic [64:0]     e_bus;
  logic [26:0]     e_ser;
  always #5 i_clk = ~i_clk;
  // pull-up on the wire; any party may pull it low
  assign wire_lvl = (tx_oe_n | tx_pin) & !pull;
  stc_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_rx(rx_pin), .i_tx_pin(wire_lvl), .o_tx_pin(tx_pin), .o_tx_pin_oe_n(tx_oe_n),
    .o_irq(irq), .o_dma_rx_req(dma_req));
  stc_remote_model remote (.i_clk(i_clk), .i_line(wire_lvl), .i_half(half), .i_nbits(nbits),
    .o_rx(rx_pin), .o_pull(pull), .o_word(word), .o_period(period), .o_got(got));
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    report_and_stop();
  endtask
  // one bus transfer; expected reply queued for the watcher
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] mask, input logic [31:0] exp, output logic [31:0] rd);
    int t;
    @(posedge i_clk);
    bus_q.push_back({(a[1:0] != 2'b00 || a > 8'h14), mask, exp});
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk);
    apb_req.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge i_clk);
      t++;
    end while (apb_rsp.pready !== 1'b1 && t < 50);
    if (t >= 50) timeout();
    rd = apb_rsp.prdata;
    apb_req <= '0;
  endtask
  // poll a register bit, bounded
  task automatic wait_reg(input logic [7:0] a, input int b, input logic lvl);
    logic [31:0] v;
    int t;
    t = 0;
    do begin
      apb(1'b0, a, 32'h0, 32'h0, 32'h0, v);
      t++;
    end while (v[b] !== lvl && t < 400);
    if (t >= 400) timeout();
  endtask
  function automatic logic [9:0] frame_bits(logic [8:0] d, int nb, logic pen, logic odd);
    logic [8:0] m;
    m = (nb == 9) ? d : {1'b0, d[7:0]};
    if (pen) m[nb-1] = ^(m & ~(9'h1 << (nb - 1))) ^ odd;
    return {1'b1, m};
  endfunction
  // bus replies, oldest note first
  always @(posedge i_clk) begin
    if (apb_rsp.pready === 1'b1) begin
      e_bus = (bus_q.size() != 0) ? bus_q.pop_front() : 'x;
      compare("read data", e_bus[31:0], apb_rsp.prdata & e_bus[63:32]);
      compare("slave error", {31'h0, e_bus[64]}, {31'h0, apb_rsp.pslverr});
    end
  end
  // frames caught by the far end
  always @(posedge i_clk) begin
    if (got === 1'b1) begin
      e_ser = (ser_q.size() != 0) ? ser_q.pop_front() : 'x;
      compare("frame bits", {22'h0, e_ser[9:0]}, {22'h0, word});
      if (e_ser[26]) compare("frame period", {16'h0, e_ser[25:10]}, {16'h0, period});
    end
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    timeout();
  end
  initial begin
    logic [31:0] v;
    logic [8:0]  d;
    int          nb, t;
    int          stop_ticks[4] = '{16, 8, 32, 24};
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 32'h7f, 32'h60, v);
    for (int a = 4; a <= 8'h14; a += 4) apb(1'b0, 8'(a), 32'h0, '1, 32'h0, v);
    apb(1'b1, 8'h18, 32'h5, '1, 32'h0, v);
    apb(1'b0, 8'h0e, 32'h0, '1, 32'h0, v);
    $display("test reset and map done");
    apb(1'b1, 8'h08, 32'h10, '1, 32'h0, v);
    apb(1'b1, 8'h0c, 32'h7, '1, 32'h0, v);
    ser_q.push_back({1'b0, 16'h0, 10'h155});
    apb(1'b1, 8'h04, 32'h55, '1, 32'h0, v);
    t = 0;
    while (tx_pin === 1'b1 && t < 400) begin
      @(posedge i_clk);
      t++;
    end
    compare("idle lead", 32'h1, {31'h0, t >= 150});
    $display("test idle frame done");
    for (int f = 0; f < 4; f++) begin
      nb = f[1] ? 9 : 8;
      wait_reg(8'h00, 5, 1'b1);
      nbits <= 4'(nb);
      apb(1'b1, 8'h10, 32'(f), '1, 32'h0, v);
      apb(1'b1, 8'h0c, {22'h0, f[1], f[0], f[0] ^ f[1], 7'h07}, '1, 32'h0, v);
      for (int j = 0; j < 2; j++) begin
        d = 9'($random(seed));
        ser_q.push_back({j == 1, 16'((1 + nb) * 16 + stop_ticks[f]),
                         frame_bits(d, nb, f[0], f[0] ^ f[1])});
        wait_reg(8'h00, 6, 1'b1);
        apb(1'b1, 8'h04, {23'h0, d}, '1, 32'h0, v);
        if (j == 1) apb(1'b0, 8'h00, 32'h0, 32'h40, 32'h0, v);
      end
      wait_reg(8'h00, 5, 1'b1);
    end
    $display("test formats done");
    ser_q.push_back({1'b0, 16'h0, 10'h2a5});
    ser_q.push_back({1'b0, 16'h0, 10'h200});
    apb(1'b1, 8'h0c, 32'h207, '1, 32'h0, v);
    apb(1'b1, 8'h04, 32'h1a5, '1, 32'h0, v);
    apb(1'b1, 8'h0c, 32'h20f, '1, 32'h0, v);
    wait_reg(8'h0c, 3, 1'b0);
    wait_reg(8'h00, 5, 1'b1);
    $display("test break done");
    apb(1'b1, 8'h0c, 32'h17, '1, 32'h0, v);
    apb(1'b1, 8'h10, 32'h0, '1, 32'h0, v);
    d = 9'($random(seed));
    remote.send(d, 8, 1'b1);
    wait_reg(8'h00, 4, 1'b1);
    compare("irq", 32'h1, {31'h0, irq});
    apb(1'b0, 8'h04, 32'h0, '1, {24'h0, d[7:0]}, v);
    apb(1'b0, 8'h00, 32'h0, 32'h10, 32'h0, v);
    remote.send(9'h0c3, 8, 1'b1);
    remote.send(9'h03c, 8, 1'b1);
    apb(1'b0, 8'h00, 32'h0, 32'h14, 32'h14, v);
    apb(1'b0, 8'h04, 32'h0, '1, 32'hc3, v);
    remote.send(9'h0f0, 8, 1'b0);
    wait_reg(8'h00, 4, 1'b1);
    apb(1'b0, 8'h00, 32'h0, 32'h1, 32'h1, v);
    apb(1'b0, 8'h04, 32'h0, '1, 32'hf0, v);
    remote.send(9'h011, 8, 1'b1);
    wait_reg(8'h00, 4, 1'b1);
    apb(1'b1, 8'h00, 32'h0, '1, 32'h0, v);
    apb(1'b0, 8'h00, 32'h0, 32'h10, 32'h0, v);
    $display("test receive done");
    apb(1'b1, 8'h14, 32'h8, '1, 32'h0, v);
    remote.send(9'h05a, 8, 1'b1);
    t = 0;
    while (dma_req !== 1'b1 && t < 400) begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 400) timeout();
    apb(1'b0, 8'h04, 32'h0, '1, 32'h5a, v);
    $display("test dma done");
    half <= 1'b1;
    apb(1'b1, 8'h14, 32'h1, '1, 32'h0, v);
    d = 9'($random(seed));
    remote.send(d, 8, 1'b1);
    wait_reg(8'h00, 4, 1'b1);
    apb(1'b0, 8'h04, 32'h0, '1, {24'h0, d[7:0]}, v);
    $display("test half duplex done");
    report_and_stop();
  end
endmodule
`default_nettype wire
